// ### dv/tb.sv
`timescale 1ns/1ps
// One compare, counted; a mismatch is reported at once
`define CHK(act, exp) begin \
  comparisons++; \
  if ((act) !== (exp)) begin \
    err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (act), (exp)); \
  end \
end
module tb;
  // ----------------------------------------------------------
  // Signals and stimulus table
  // ----------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic busy_out;
  logic taken_out;
  logic [15:0] pc_out;
  logic [7:0] flags_out;
  int err_count = 0;
  int comparisons = 0;
  int busy_cnt = 0; // Busy cycles seen since the last start
  logic [31:0] rd;
  logic er;
  // One evaluation: inputs, then expected pc and outcome
  typedef struct packed {
    bsc_pkg::op_t op;
    logic two;
    logic [2:0] sel;
    logic [6:0] k;
    logic [7:0] io;
    logic [7:0] flags;
    logic [15:0] pc;
    logic [15:0] exp_pc;
    logic tk;
  } row_t;
  row_t rows [] = '{
    '{bsc_pkg::OP_SKIP_IF_IO_BIT_CLEAR, 0, 3, 0, 8'hF7, 8'hF0,
      16'h0100, 16'h0102, 1},
    '{bsc_pkg::OP_SKIP_IF_IO_BIT_CLEAR, 1, 3, 0, 8'hFF, 8'h00,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_SKIP_IF_IO_BIT_SET, 1, 7, 0, 8'h80, 8'h00,
      16'h0100, 16'h0103, 1},
    '{bsc_pkg::OP_SKIP_IF_IO_BIT_SET, 0, 7, 0, 8'h7F, 8'h00,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_FLAG_BIT_SET, 0, 5, 7'h10, 0, 8'h20,
      16'h0100, 16'h0111, 1},
    '{bsc_pkg::OP_BRANCH_IF_FLAG_BIT_CLEAR, 0, 5, 7'h10, 0, 8'h20,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_FLAG_BIT_CLEAR, 0, 6, 7'h7F, 0, 8'h20,
      16'h0100, 16'h0100, 1},
    '{bsc_pkg::OP_BRANCH_IF_EQUAL, 0, 0, 7'h05, 0, 8'hF2,
      16'h0100, 16'h0106, 1},
    '{bsc_pkg::OP_BRANCH_IF_EQUAL, 0, 0, 7'h05, 0, 8'h00,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_NOT_EQUAL, 0, 0, 7'h40, 0, 8'h00,
      16'h0100, 16'h00C1, 1},
    '{bsc_pkg::OP_BRANCH_IF_NOT_EQUAL, 0, 0, 7'h40, 0, 8'h02,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_NOT_EQUAL, 0, 0, 7'h40, 0, 8'h00,
      16'h0000, 16'hFFC1, 1},
    '{bsc_pkg::OP_BRANCH_IF_CARRY_SET, 0, 0, 7'h3F, 0, 8'h01,
      16'h0100, 16'h0140, 1},
    '{bsc_pkg::OP_BRANCH_IF_CARRY_CLEAR, 0, 0, 7'h02, 0, 8'h01,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_CARRY_CLEAR, 0, 0, 7'h02, 0, 8'h00,
      16'h0100, 16'h0103, 1},
    '{bsc_pkg::OP_BRANCH_IF_SAME_OR_HIGHER, 0, 0, 7'h02, 0, 8'h00,
      16'h0100, 16'h0103, 1},
    '{bsc_pkg::OP_BRANCH_IF_SAME_OR_HIGHER, 0, 0, 7'h02, 0, 8'h01,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_LOWER, 0, 0, 7'h02, 0, 8'h01,
      16'h0100, 16'h0103, 1},
    '{bsc_pkg::OP_BRANCH_IF_LOWER, 0, 0, 7'h02, 0, 8'h00,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_MINUS, 0, 0, 7'h02, 0, 8'h04,
      16'h0100, 16'h0103, 1},
    '{bsc_pkg::OP_BRANCH_IF_MINUS, 0, 0, 7'h02, 0, 8'h00,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_PLUS, 0, 0, 7'h02, 0, 8'h00,
      16'h0100, 16'h0103, 1},
    '{bsc_pkg::OP_BRANCH_IF_PLUS, 0, 0, 7'h02, 0, 8'h04,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_GREATER_EQUAL_SIGNED, 0, 0, 7'h02, 0, 8'h0C,
      16'h0100, 16'h0103, 1},
    '{bsc_pkg::OP_BRANCH_IF_GREATER_EQUAL_SIGNED, 0, 0, 7'h02, 0, 8'h04,
      16'h0100, 16'h0101, 0},
    '{bsc_pkg::OP_BRANCH_IF_GREATER_EQUAL_SIGNED, 0, 0, 7'h02, 0, 8'h08,
      16'h0100, 16'h0101, 0},
    // Unused code: never branches, falls through
    '{bsc_pkg::op_t'(4'hD), 0, 0, 7'h05, 0, 8'hFF,
      16'h0100, 16'h0101, 0}
  };
  // ----------------------------------------------------------
  // Clock, busy counter and device
  // ----------------------------------------------------------
  always #5 mclk_in = ~mclk_in;
  // Sampled mid-cycle so the count never races the edge
  always @(negedge mclk_in) begin
    if (busy_out === 1'b1) busy_cnt++;
  end
  branch_skip_condition_unit dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .busy_out(busy_out), .taken_out(taken_out), .pc_out(pc_out),
    .flags_out(flags_out)
  );
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One APB transfer; answer taken at the rising edge that shows pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    r = 32'h0000_0000;
    e = 1'b0;
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // Read just after the edge: the values that edge sampled
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    // A slave that never answers ends the run
    if (pready_out !== 1'b1) begin
      err_count++;
      complete_run();
    end else begin
      r = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask
  // Load operands, start, then check pc, outcome, flags and timing
  task automatic run_row(input row_t r);
    logic [31:0] d;
    logic e;
    logic [1:0] cyc;
    cyc = !r.tk ? 2'd1 : (r.op < 2 && r.two) ? 2'd3 : 2'd2;
    apb(1'b1, 12'h008, {16'h0000, r.pc}, d, e);
    apb(1'b1, 12'h00C, {24'h00_0000, r.io}, d, e);
    apb(1'b1, 12'h010, {24'h00_0000, r.flags}, d, e);
    apb(1'b1, 12'h004, {16'h0000, r.op, r.two, r.sel, 1'b0, r.k}, d, e);
    busy_cnt = 0;
    apb(1'b1, 12'h000, 32'h0000_0001, d, e);
    repeat (5) @(posedge mclk_in);
    `CHK(busy_cnt, int'(cyc))
    `CHK(pc_out, r.exp_pc)
    `CHK(taken_out, r.tk)
    `CHK(flags_out, r.flags)
    apb(1'b0, 12'h014, 32'h0000_0000, d, e);
    `CHK(d, {27'h000_0000, cyc, r.op < 2, r.tk, 1'b0})
    `CHK(e, 1'b0)
    apb(1'b0, 12'h008, 32'h0000_0000, d, e);
    `CHK(d, {16'h0000, r.exp_pc})
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    // Reset values seen at the ports and in status
    `CHK({pc_out, flags_out, busy_out, taken_out}, 26'h000_0000)
    apb(1'b0, 12'h014, 32'h0000_0000, rd, er);
    `CHK(rd, 32'h0000_0000)
    // Unmapped address answers with an error
    apb(1'b0, 12'h018, 32'h0000_0000, rd, er);
    `CHK(er, 1'b1)
    foreach (rows[i]) run_row(rows[i]);
    // Reset in mid-run clears the program counter and outcome
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    `CHK({pc_out, taken_out}, 17'h0_0000)
    rst_b_in <= 1'b1;
    run_row(rows[2]);
    complete_run();
  end
endmodule

// ### include/bsc_defines.svh
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH
// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define BSC_ADDR_CTRL 12'h000
`define BSC_ADDR_INSN 12'h004
`define BSC_ADDR_PC 12'h008
`define BSC_ADDR_IO 12'h00C
`define BSC_ADDR_FLAGS 12'h010
`define BSC_ADDR_STATUS 12'h014
// ---------------------------------------------------------------
// Field positions and widths
// ---------------------------------------------------------------
`define BSC_OP_LSB 12
`define BSC_OP_W 4
`define BSC_SEL_LSB 8
`define BSC_SEL_W 3
`define BSC_K_LSB 0
`define BSC_K_W 7
`define BSC_NEXT2_BIT 11
// Flag bit positions in the cpu flag register
`define BSC_FLAG_C 3'd0
`define BSC_FLAG_Z 3'd1
`define BSC_FLAG_N 3'd2
`define BSC_FLAG_V 3'd3
// Skip distances, cycle counts and reset values
`define BSC_STEP_ONE 16'h0001
`define BSC_STEP_TWO 16'h0002
`define BSC_STEP_THREE 16'h0003
`define BSC_CYC_ONE 2'd1
`define BSC_CYC_TWO 2'd2
`define BSC_CYC_THREE 2'd3
`define BSC_PC_RESET 16'h0000
`define BSC_FLAGS_RESET 8'h00
`endif

// ### include/bsc_pkg.sv
package bsc_pkg;
  // Instruction selector held in the opcode field
  typedef enum logic [3:0] {
    OP_SKIP_IF_IO_BIT_CLEAR = 4'h0,
    OP_SKIP_IF_IO_BIT_SET = 4'h1,
    OP_BRANCH_IF_FLAG_BIT_SET = 4'h2,
    OP_BRANCH_IF_FLAG_BIT_CLEAR = 4'h3,
    OP_BRANCH_IF_EQUAL = 4'h4,
    OP_BRANCH_IF_NOT_EQUAL = 4'h5,
    OP_BRANCH_IF_CARRY_SET = 4'h6,
    OP_BRANCH_IF_CARRY_CLEAR = 4'h7,
    OP_BRANCH_IF_SAME_OR_HIGHER = 4'h8,
    OP_BRANCH_IF_LOWER = 4'h9,
    OP_BRANCH_IF_MINUS = 4'hA,
    OP_BRANCH_IF_PLUS = 4'hB,
    OP_BRANCH_IF_GREATER_EQUAL_SIGNED = 4'hC
  } op_t;
  // Result of one evaluation
  typedef struct packed {
    logic taken;
    logic is_skip;
    logic [1:0] cycles;
    logic [15:0] next_pc;
  } eval_result_t;
endpackage

// ### verilog/branch_skip_condition_unit.sv
`timescale 1ns/1ps
`include "bsc_defines.svh"
// Notes on behaviour
// - I/O bit clear skips next instruction
// - I/O bit set skips next instruction
// - flag bit set branches pc+k+1
// - flag bit clear branches pc+k+1
// - branch when zero flag is one
// - branch when zero flag is zero
// - branch when carry flag is one
// - branch when carry flag is zero
// - same or higher uses carry zero
// - lower uses carry one
// - branch when negative flag is one
// - no instruction changes any flag
// - branch when negative flag is zero
// - branch when N xor V zero
module branch_skip_condition_unit (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic busy_out,
  output logic taken_out,
  output logic [15:0] pc_out,
  output logic [7:0] flags_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} state_t;
  state_t state_q; // Execution sequencer
  logic [15:0] insn_q; // Instruction under test
  logic [15:0] pc_q; // Program counter
  logic [7:0] io_q; // Addressed I/O register value
  logic [7:0] flags_q; // cpu flag register copy
  logic [1:0] cnt_q; // Cycles remaining
  logic taken_q; // Last outcome
  logic skip_q; // Last was a skip
  logic [1:0] cyc_q; // Last cycle count
  bsc_pkg::eval_result_t res;
  logic setup, wr, go;
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Access phase of a transfer; one wait state for every transfer
  assign setup = psel_in & penable_in & ~pready_out;
  assign wr = setup & pwrite_in;
  // Writing control bit 0 starts one evaluation when idle
  assign go = wr && paddr_in == `BSC_ADDR_CTRL && pwdata_in[0]
              && state_q == ST_IDLE;
  bsc_cond_eval #(.PC_W(16)) u_eval (
    .insn_in(insn_q),
    .pc_in(pc_q),
    .io_in(io_q),
    .flags_in(flags_q),
    .res_out(res)
  );
  // Ready pulses once in the second access cycle
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup;
      // Addresses above the status register answer with an error
      pslverr_out <= setup && paddr_in > `BSC_ADDR_STATUS;
    end
  end
  // Read data mux, registered
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup && !pwrite_in) begin
      case (paddr_in)
        `BSC_ADDR_CTRL: prdata_out <= {31'h0000_0000, busy_out};
        `BSC_ADDR_INSN: prdata_out <= {16'h0000, insn_q};
        `BSC_ADDR_PC: prdata_out <= {16'h0000, pc_q};
        `BSC_ADDR_IO: prdata_out <= {24'h00_0000, io_q};
        `BSC_ADDR_FLAGS: prdata_out <= {24'h00_0000, flags_q};
        `BSC_ADDR_STATUS: prdata_out <= {27'h000_0000, cyc_q,
                                         skip_q, taken_q, busy_out};
        default: prdata_out <= 32'h0000_0000;
      endcase
    end else begin
      prdata_out <= 32'h0000_0000;
    end
  end
  // ---------------------------------------------------------------
  // Software loaded operands
  // ---------------------------------------------------------------
  // Writes are refused while an evaluation runs
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      insn_q <= 16'h0000;
      io_q <= 8'h00;
    end else if (wr && state_q == ST_IDLE) begin
      if (paddr_in == `BSC_ADDR_INSN) begin
        insn_q <= pwdata_in[15:0];
      end
      if (paddr_in == `BSC_ADDR_IO) begin
        io_q <= pwdata_in[7:0];
      end
    end
  end
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags_q <= `BSC_FLAGS_RESET;
    end else if (wr && state_q == ST_IDLE &&
                 paddr_in == `BSC_ADDR_FLAGS) begin
      flags_q <= pwdata_in[7:0];
    end
  end
  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Program counter loads the computed target at start
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pc_q <= `BSC_PC_RESET;
    end else if (go) begin
      pc_q <= res.next_pc;
    end else if (wr && state_q == ST_IDLE &&
                 paddr_in == `BSC_ADDR_PC) begin
      pc_q <= pwdata_in[15:0];
    end
  end
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 2'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_WAIT;
            cnt_q <= 2'(res.cycles - `BSC_CYC_ONE);
          end
        end
        ST_WAIT: begin
          if (cnt_q == 2'd0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= 2'(cnt_q - 2'd1);
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // Outcome capture
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      taken_q <= 1'b0;
      skip_q <= 1'b0;
      cyc_q <= 2'd0;
    end else if (go) begin
      taken_q <= res.taken;
      skip_q <= res.is_skip;
      cyc_q <= res.cycles;
    end
  end
  // Registered mirrors of internal state
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      taken_out <= 1'b0;
      pc_out <= `BSC_PC_RESET;
      flags_out <= `BSC_FLAGS_RESET;
    end else begin
      busy_out <= go || (state_q == ST_WAIT && cnt_q != 2'd0);
      taken_out <= go ? res.taken : taken_q;
      pc_out <= go ? res.next_pc : pc_q;
      flags_out <= flags_q;
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Start of one evaluation
  sequence s_start;
    go;
  endsequence
  // Busy for exactly one cycle
  sequence s_one_cycle;
    busy_out ##1 !busy_out;
  endsequence
  // Busy for exactly two cycles
  sequence s_two_cycles;
    busy_out ##1 busy_out ##1 !busy_out;
  endsequence
  // Busy for exactly three cycles
  sequence s_three_cycles;
    busy_out [*3] ##1 !busy_out;
  endsequence
  AST_FLAGS_STABLE: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in) state_q == ST_WAIT |-> $stable(flags_q))
    else $error("flags changed during evaluation");
  AST_FLAGS_OUT: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in) state_q == ST_WAIT |-> flags_out == flags_q)
    else $error("flag output differs during evaluation");
  AST_SKIP_CLEAR: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h0) and !io_q[insn_q[10:8]]
    |=> pc_q == $past(pc_q) + (insn_q[11] ? 16'd3 : 16'd2))
    else $error("clear skip wrong target");
  AST_SKIP_CLEAR_KEEP: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h0) and io_q[insn_q[10:8]]
    |=> pc_q == $past(pc_q) + 16'd1)
    else $error("clear skip taken wrongly");
  AST_SKIP_SET: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h1) and !io_q[insn_q[10:8]]
    |=> pc_q == $past(pc_q) + 16'd1)
    else $error("set skip taken wrongly");
  AST_SKIP_SET_TAKEN: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h1) and io_q[insn_q[10:8]]
    |=> pc_q == $past(pc_q) + (insn_q[11] ? 16'd3 : 16'd2))
    else $error("set skip wrong target");
  AST_BR_FLAG_SET: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h2)
    |-> res.taken == flags_q[insn_q[10:8]])
    else $error("flag set branch condition wrong");
  AST_BR_FLAG_CLR: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h3)
    |-> res.taken == !flags_q[insn_q[10:8]])
    else $error("flag clear branch condition wrong");
  AST_BR_EQ: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h4) |-> res.taken == flags_q[1])
    else $error("equal branch condition wrong");
  AST_BR_NE: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h5) |-> res.taken == !flags_q[1])
    else $error("not equal branch condition wrong");
  AST_BR_CS: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h6) |-> res.taken == flags_q[0])
    else $error("carry set condition wrong");
  AST_BR_CC: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h7) |-> res.taken == !flags_q[0])
    else $error("carry clear condition wrong");
  AST_BR_SH: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h8) |-> res.taken == !flags_q[0])
    else $error("same or higher condition wrong");
  AST_BR_LO: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'h9) |-> res.taken == flags_q[0])
    else $error("lower condition wrong");
  AST_BR_MI: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'hA) |-> res.taken == flags_q[2])
    else $error("minus condition wrong");
  AST_BR_PL: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'hB) |-> res.taken == !flags_q[2])
    else $error("plus condition wrong");
  AST_BR_GE: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and (insn_q[15:12] == 4'hC)
    |-> res.taken == !(flags_q[2] ^ flags_q[3]))
    else $error("signed compare wrong");
  AST_BR_TARGET: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and !res.is_skip and res.taken |=> pc_q ==
    16'($past(pc_q) + {{9{insn_q[6]}}, insn_q[6:0]} + 16'd1))
    else $error("branch target wrong");
  AST_BR_NT_PC: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and !res.is_skip and !res.taken
    |=> pc_q == $past(pc_q) + 16'd1)
    else $error("untaken branch target wrong");
  AST_BR_CYC: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and !res.is_skip and res.taken |=> s_two_cycles)
    else $error("taken branch busy length wrong");
  AST_NT_CYC: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and !res.taken |=> s_one_cycle)
    else $error("not taken busy length wrong");
  AST_SKIP_CYC2: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and res.is_skip and res.taken and !insn_q[11]
    |=> s_two_cycles)
    else $error("short skip busy length wrong");
  AST_SKIP_CYC3: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    s_start and res.is_skip and res.taken and insn_q[11]
    |=> s_three_cycles)
    else $error("long skip busy length wrong");
  // Bus answer is a single pulse
  AST_PREADY_PULSE: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in) pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  // Error only beside the answer
  AST_ERR_WITH_READY: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in) pslverr_out |-> pready_out)
    else $error("error shown without ready");
  // Read data quiet between answers
  AST_RDATA_IDLE: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in) !pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data shown outside answer");
  // Operand writes refused while busy
  AST_OPERANDS_HELD: assert property (@(posedge mclk_in)
    disable iff (!rst_b_in)
    state_q == ST_WAIT
    |=> $stable(insn_q) && $stable(pc_q) && $stable(io_q))
    else $error("operand written during evaluation");
endmodule

// ### verilog/bsc_cond_eval.sv
`timescale 1ns/1ps
`include "bsc_defines.svh"
// Pure combinational condition and target evaluation
module bsc_cond_eval #(
  parameter int PC_W = 16
) (
  input wire logic [15:0] insn_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] io_in,
  input wire logic [7:0] flags_in,
  output bsc_pkg::eval_result_t res_out
);
  logic [3:0] op;
  logic [2:0] sel;
  logic [6:0] k;
  logic [PC_W-1:0] k_ext;
  logic c, z, n, v, cond, skip;
  assign op = insn_in[`BSC_OP_LSB +: `BSC_OP_W];
  assign sel = insn_in[`BSC_SEL_LSB +: `BSC_SEL_W];
  assign k = insn_in[`BSC_K_LSB +: `BSC_K_W];
  assign k_ext = {{(PC_W-7){k[6]}}, k};
  assign c = flags_in[`BSC_FLAG_C];
  assign z = flags_in[`BSC_FLAG_Z];
  assign n = flags_in[`BSC_FLAG_N];
  assign v = flags_in[`BSC_FLAG_V];
  // Condition decode per opcode
  always_comb begin
    skip = 1'b0;
    case (bsc_pkg::op_t'(op))
      bsc_pkg::OP_SKIP_IF_IO_BIT_CLEAR: begin
        skip = 1'b1;
        cond = ~io_in[sel];
      end
      bsc_pkg::OP_SKIP_IF_IO_BIT_SET: begin
        skip = 1'b1;
        cond = io_in[sel];
      end
      bsc_pkg::OP_BRANCH_IF_FLAG_BIT_SET: cond = flags_in[sel];
      bsc_pkg::OP_BRANCH_IF_FLAG_BIT_CLEAR: cond = ~flags_in[sel];
      bsc_pkg::OP_BRANCH_IF_EQUAL: cond = z;
      bsc_pkg::OP_BRANCH_IF_NOT_EQUAL: cond = ~z;
      bsc_pkg::OP_BRANCH_IF_CARRY_SET: cond = c;
      bsc_pkg::OP_BRANCH_IF_CARRY_CLEAR: cond = ~c;
      bsc_pkg::OP_BRANCH_IF_SAME_OR_HIGHER: cond = ~c;
      bsc_pkg::OP_BRANCH_IF_LOWER: cond = c;
      bsc_pkg::OP_BRANCH_IF_MINUS: cond = n;
      bsc_pkg::OP_BRANCH_IF_PLUS: cond = ~n;
      bsc_pkg::OP_BRANCH_IF_GREATER_EQUAL_SIGNED: cond = ~(n ^ v);
      // Unused codes never branch
      default: cond = 1'b0;
    endcase
  end
  // Target and cycle count
  always_comb begin
    res_out.taken = cond;
    res_out.is_skip = skip;
    res_out.cycles = `BSC_CYC_ONE;
    res_out.next_pc = 16'(pc_in + PC_W'(`BSC_STEP_ONE));
    if (cond && skip) begin
      if (insn_in[`BSC_NEXT2_BIT]) begin
        res_out.cycles = `BSC_CYC_THREE;
        res_out.next_pc = 16'(pc_in + PC_W'(`BSC_STEP_THREE));
      end else begin
        res_out.cycles = `BSC_CYC_TWO;
        res_out.next_pc = 16'(pc_in + PC_W'(`BSC_STEP_TWO));
      end
    end else if (cond) begin
      res_out.cycles = `BSC_CYC_TWO;
      res_out.next_pc = 16'(pc_in + k_ext + PC_W'(`BSC_STEP_ONE));
    end
  end
endmodule
